// [design/lmd_mode_ctrl.sv]
// Purpose: Mode control, latches and error detect of an 8-channel LED sink
// Assumes: Pins sampled on the 20 MHz system clock; serial clock is a pin
// Notes: Registers on a plain 3-bit address port, read data one cycle later
//
// Contract
// - Trigger pulse recognised in every phase
// - Error detection only in special mode
// - Switching strobe selects mode, latches nothing
// - Special strobe loads configuration latch
// - Error flags shift out on serial output
// - Below-threshold channel stores low flag
// - Top config bit multiplier, rest gain
// - 1-0-1 enters switching; 4th edge picks
// - Start in normal mode
// - Normal strobe high makes latch transparent
// - Configuration resets to gain 127/128, multiplier 1
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "lmd_map.svh"
module lmd_mode_ctrl
   import lmd_pkg::*;
(
   input wire logic I_CLK_SYS,
   input wire logic I_RSTN,
   input wire logic I_CE,
   input wire logic I_SCLK,
   input wire logic I_SERIAL_INPUT,
   input wire logic I_STROBE_PIN_MULTI,
   input wire logic I_OE_TRIG_N,
   input wire logic [7:0] I_CHAN_LOW_CUR,
   input wire logic [2:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_SINK_CHANNELS,
   output logic O_SERIAL_OUTPUT,
   output logic O_CURRENT_MULT,
   output logic [6:0] O_GAIN_CODE,
   output logic [1:0] O_PHASE,
   output logic O_IRQ,
   output logic [7:0] O_RDATA
);
   localparam int ED_CYC = `LMD_ED_CYC;
   localparam logic [5:0] ED_LAST = 6'(ED_CYC - 1);

   lmd_pins_t pin_raw;
   lmd_pins_t pin;
   lmd_phase_t phase;
   lmd_phase_t next_phase;
   lmd_cfg_t cfg;
   logic sclk_d;
   logic strobe_d;
   logic [1:0] oe_hist;
   logic [7:0] out_latch;
   logic [7:0] shreg;
   logic [5:0] det_cnt;
   logic [`LMD_EV_W-1:0] evt;
   logic [`LMD_EV_W-1:0] ien;
   logic blank_force;

   // Address compare shared by the decoders
   function automatic logic is_adr(input logic [2:0] a, input logic [2:0] r);
      return a == r;
   endfunction : is_adr

   assign pin_raw = '{sclk: I_SCLK, serial_input: I_SERIAL_INPUT,
                      strobe: I_STROBE_PIN_MULTI, oe_n: I_OE_TRIG_N,
                      chan_low: I_CHAN_LOW_CUR};

   // All pin levels cross in together so sdi lines up with its clock
   lmd_sync2 #(.W(12)) u_sync (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RSTN),
      .i_ce(I_CE),
      .i_d(pin_raw),
      .o_q(pin)
   );

   // Edge history of the synchronised serial clock and strobe
   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         sclk_d <= 1'b0;
         strobe_d <= 1'b0;
      end else if (I_CE) begin
         sclk_d <= pin.sclk;
         strobe_d <= pin.strobe;
      end
   end

   wire sclk_rise = pin.sclk & ~sclk_d;
   wire strobe_rise = pin.strobe & ~strobe_d;
   wire oe_low = ~pin.oe_n;

   // One-clock low pulse on the enable pin, as seen by the serial clock
   wire trig = sclk_rise & pin.oe_n & (oe_hist == 2'b10);

   // Enable history sampled on serial clock rising edges
   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         oe_hist <= 2'b11; // Idle level of the pulled-up pin, so no false pulse
      end else if (I_CE && sclk_rise) begin
         oe_hist <= {oe_hist[0], pin.oe_n};
      end
   end

   // Phase sequencing; the trigger is checked ahead of everything else
   always_comb begin
      next_phase = phase;
      if (trig) begin
         next_phase = LMD_SWITCH;
      end else begin
         case (phase)
            LMD_SWITCH: begin
               // Fourth edge: strobe level picks the next mode
               if (sclk_rise) begin
                  next_phase = pin.strobe ? LMD_SPECIAL : LMD_NORMAL;
               end
            end
            LMD_SPECIAL: next_phase = LMD_SPECIAL;
            LMD_NORMAL: next_phase = LMD_NORMAL;
            default: next_phase = LMD_NORMAL;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         phase <= LMD_NORMAL;
      end else if (I_CE) begin
         phase <= next_phase;
      end
   end

   wire in_normal = (phase == LMD_NORMAL);
   wire in_special = (phase == LMD_SPECIAL);

   // Detect waits out the minimum low time before sampling the comparators
   wire det_run = in_special & oe_low;
   wire det_load = det_run & (det_cnt == ED_LAST);
   wire [7:0] det_flags = ~pin.chan_low;

   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         det_cnt <= 6'h00;
      end else if (I_CE) begin
         if (!det_run) begin
            det_cnt <= 6'h00;
         end else if (det_cnt <= ED_LAST) begin
            det_cnt <= det_cnt + 6'h01; // Stops past the load, one load per low
         end
      end
   end

   // Shift path; SERIAL_OUTPUT is the oldest bit, for cascading
   lmd_shreg u_shreg (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RSTN),
      .i_ce(I_CE),
      .i_shift(sclk_rise),
      .i_sdi(pin.serial_input),
      .i_load(det_load),
      .i_load_val(det_flags),
      .o_q(shreg)
   );
   assign O_SERIAL_OUTPUT = shreg[7];

   // Output latch is transparent only in normal mode
   wire olat_open = in_normal & pin.strobe & ~trig;
   // Config latch takes a rising strobe; a level held over from the
   // switching decision would otherwise overwrite it
   wire cfg_wr = in_special & strobe_rise & ~trig;

   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         out_latch <= 8'h00;
         cfg <= `LMD_CFG_RST;
      end else if (I_CE) begin
         if (olat_open) begin
            out_latch <= shreg;
         end
         if (cfg_wr) begin
            cfg <= shreg;
         end
      end
   end

   // Register port decode
   wire wr_clr = I_WR & is_adr(I_ADDR, `LMD_ADR_CLR);
   wire wr_ien = I_WR & is_adr(I_ADDR, `LMD_ADR_IEN);
   wire wr_ctrl = I_WR & is_adr(I_ADDR, `LMD_ADR_CTRL);

   // Event sources; an event in the clear cycle survives
   wire ev_enter = trig & (phase != LMD_SWITCH);
   wire [`LMD_EV_W-1:0] ev_set = {
      det_load & ~(&det_flags),
      det_load,
      cfg_wr,
      (next_phase == LMD_NORMAL) & (phase == LMD_SWITCH),
      (next_phase == LMD_SPECIAL) & (phase == LMD_SWITCH),
      ev_enter
   };
   wire [`LMD_EV_W-1:0] ev_clr = wr_clr ? I_WDATA[`LMD_EV_W-1:0] : '0;

   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         evt <= '0;
         ien <= '0;
         blank_force <= 1'b0;
      end else if (I_CE) begin
         evt <= (evt & ~ev_clr) | ev_set;
         if (wr_ien) begin
            ien <= I_WDATA[`LMD_EV_W-1:0];
         end
         if (wr_ctrl) begin
            blank_force <= I_WDATA[0];
         end
      end
   end

   // Read mux; unmapped or write-only reads return zero
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (is_adr(I_ADDR, `LMD_ADR_PHASE)) begin
         rd_mux = {6'h00, phase};
      end else if (is_adr(I_ADDR, `LMD_ADR_EVT)) begin
         rd_mux = {2'h0, evt};
      end else if (is_adr(I_ADDR, `LMD_ADR_IEN)) begin
         rd_mux = {2'h0, ien};
      end else if (is_adr(I_ADDR, `LMD_ADR_CFG)) begin
         rd_mux = cfg;
      end else if (is_adr(I_ADDR, `LMD_ADR_OLAT)) begin
         rd_mux = out_latch;
      end else if (is_adr(I_ADDR, `LMD_ADR_SHR)) begin
         rd_mux = shreg;
      end else if (is_adr(I_ADDR, `LMD_ADR_CTRL)) begin
         rd_mux = {7'h00, blank_force};
      end
   end

   // Registered outputs; blanking ignores whatever the latch holds
   wire [7:0] next_sink = (pin.oe_n | blank_force) ? 8'h00 : out_latch;

   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_SINK_CHANNELS <= 8'h00;
         O_CURRENT_MULT <= 1'(`LMD_CFG_RST >> `LMD_CFG_CM);
         O_GAIN_CODE <= 7'h7F;
         O_PHASE <= 2'b00;
         O_IRQ <= 1'b0;
         O_RDATA <= 8'h00;
      end else if (I_CE) begin
         O_SINK_CHANNELS <= next_sink;
         O_CURRENT_MULT <= cfg.cm;
         O_GAIN_CODE <= cfg.gain;
         O_PHASE <= phase;
         O_IRQ <= |(evt & ien);
         O_RDATA <= I_RD ? rd_mux : 8'h00;
      end
   end

   // Checks against the logic above
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RSTN);

   a_trig_enter: assert property (I_CE && trig |=> phase == LMD_SWITCH)
      else $error("trigger pulse did not enter switching");

   a_switch_pick: assert property (I_CE && phase == LMD_SWITCH && sclk_rise && !trig
      |=> phase == ($past(pin.strobe) ? LMD_SPECIAL : LMD_NORMAL))
      else $error("switching edge picked the wrong mode");

   a_det_special: assert property (det_load |-> in_special && oe_low)
      else $error("error detect outside special mode");

   a_det_wait: assert property (I_CE && det_run && det_cnt == 6'h00
      |-> !det_load [*8])
      else $error("detect sampled before the minimum low time");

   a_det_flags: assert property (I_CE && det_load |=> shreg == ~$past(pin.chan_low))
      else $error("error flags not loaded inverted");

   a_switch_hold: assert property (I_CE && phase == LMD_SWITCH
      |=> $stable(out_latch) && $stable(cfg))
      else $error("latch changed during switching");

   a_cfg_write: assert property (I_CE && cfg_wr |=> cfg == $past(shreg))
      else $error("configuration latch not written");

   a_olat_follow: assert property (I_CE && olat_open |=> out_latch == $past(shreg))
      else $error("output latch not transparent");

   a_sdo_order: assert property (I_CE && sclk_rise && !det_load
      |=> O_SERIAL_OUTPUT == $past(shreg[6]))
      else $error("serial output out of order");

   a_blank_out: assert property (I_CE && pin.oe_n |=> O_SINK_CHANNELS == 8'h00)
      else $error("channels driven while enable high");

   a_cfg_out: assert property (I_CE ##1 I_CE |-> ##1 O_GAIN_CODE == $past(cfg.gain))
      else $error("gain output does not track the latch");

endmodule : lmd_mode_ctrl

// [design/lmd_map.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 20 MHz system clock, 8-bit register port
// Notes: Included by bare name
`ifndef LMD_MAP_SVH
`define LMD_MAP_SVH
// Register indices on the 3-bit address port
`define LMD_ADR_PHASE 3'h0
`define LMD_ADR_EVT 3'h1
`define LMD_ADR_CLR 3'h2
`define LMD_ADR_IEN 3'h3
`define LMD_ADR_CFG 3'h4
`define LMD_ADR_OLAT 3'h5
`define LMD_ADR_SHR 3'h6
`define LMD_ADR_CTRL 3'h7
// Event bit positions
`define LMD_EV_SWITCH 0
`define LMD_EV_SPECIAL 1
`define LMD_EV_NORMAL 2
`define LMD_EV_CFG 3
`define LMD_EV_DET 4
`define LMD_EV_ERR 5
`define LMD_EV_W 6
// Configuration: top bit is the multiplier, rest the gain code
`define LMD_CFG_RST 8'hFF
`define LMD_CFG_CM 7
// Error-detect minimum low time on the enable pin
`define LMD_ED_MIN_NS 2010
`define LMD_CLK_NS 50
`define LMD_ED_CYC ((`LMD_ED_MIN_NS + `LMD_CLK_NS - 1) / `LMD_CLK_NS)
`endif

// [design/lmd_pkg.sv]
// Purpose: Types shared by the LED mode-control block
// Assumes: Nothing beyond the map header
// Notes: Types only; numbers live in lmd_map.svh
package lmd_pkg;
   typedef enum logic [1:0] {
      LMD_NORMAL = 2'b00,
      LMD_SWITCH = 2'b01,
      LMD_SPECIAL = 2'b10
   } lmd_phase_t;
   // Synchronised pin set
   typedef struct packed {
      logic sclk;
      logic serial_input;
      logic strobe;
      logic oe_n;
      logic [7:0] chan_low;
   } lmd_pins_t;
   // Configuration latch layout
   typedef struct packed {
      logic cm;
      logic [6:0] gain;
   } lmd_cfg_t;
endpackage : lmd_pkg

// [design/lmd_sync2.sv]
// Purpose: Two-flop synchroniser for pin-level inputs
// Assumes: Inputs are asynchronous to the system clock
// Notes: First stage is read only by the second
`timescale 1ns/10ps
module lmd_sync2 #(
   parameter int W = 12
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta;
   // Two stages; the first is never looked at elsewhere
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta <= '0;
         o_q <= '0;
      end else if (i_ce) begin
         meta <= i_d;
         o_q <= meta;
      end
   end
endmodule : lmd_sync2

// [design/lmd_shreg.sv]
// Purpose: 8-bit serial shift register with parallel load
// Assumes: Shift and load are one-cycle pulses
// Notes: Load wins over shift when both arrive together
`timescale 1ns/10ps
module lmd_shreg (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_shift,
   input wire logic i_sdi,
   input wire logic i_load,
   input wire logic [7:0] i_load_val,
   output logic [7:0] o_q
);
   // Detect results must not be lost to a coincident shift
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_q <= 8'h00;
      end else if (i_ce) begin
         if (i_load) begin
            o_q <= i_load_val;
         end else if (i_shift) begin
            o_q <= {o_q[6:0], i_sdi};
         end
      end
   end
endmodule : lmd_shreg

// [tb/lmd_ctl_model.sv]
// Purpose: System controller model for the serial and shared control pins
// Assumes: Each pin level is held 4 system clocks so the synchronisers catch it
// Notes: Enable idles high, where its pull-up would leave it
`timescale 1ns/10ps
module lmd_ctl_model (
   input wire logic i_clk,
   output logic o_sclk,
   output logic o_sdi,
   output logic o_strobe,
   output logic o_oe_n
);
   // Idle pin levels: serial clock stands low outside frames
   initial begin
      o_sclk = 1'b0;
      o_sdi = 1'b0;
      o_strobe = 1'b0;
      o_oe_n = 1'b1;
   end

   // One serial clock period; data and enable settle before the rise
   task automatic bit_clk(input logic d, input logic oe_n);
      o_sdi <= d;
      o_oe_n <= oe_n;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b0;
   endtask : bit_clk

   // Whole byte, first bit out is the top one; code goes in before any strobe
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         bit_clk(b[i], 1'b1);
      end
   endtask : send_byte

   // Positive strobe pulse, wide enough to be seen
   task automatic strobe_pulse;
      o_strobe <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_strobe <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask : strobe_pulse

   // Enable samples 1,0,1, then strobe level picks the mode at the 4th edge
   task automatic mode_sel(input logic sel);
      bit_clk(1'b0, 1'b1);
      bit_clk(1'b0, 1'b0);
      bit_clk(1'b0, 1'b1);
      o_strobe <= sel;
      bit_clk(1'b0, 1'b1);
      o_strobe <= 1'b0;
   endtask : mode_sel

   // Enable held low n cycles; 60 cycles gives 3000 ns, above the detect minimum
   task automatic detect(input int n);
      o_oe_n <= 1'b0;
      repeat (n) @(posedge i_clk);
      o_oe_n <= 1'b1;
      repeat (6) @(posedge i_clk);
   endtask : detect
endmodule : lmd_ctl_model

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the LED mode-control block
// Assumes: Serial clock far slower than the system clock
// Notes: Reference model kept in plain variables, compared at every result
`timescale 1ns/10ps
`include "lmd_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
   import lmd_pkg::*;
;
   logic clk, rst_n, ce, wr, rd_s, sclk, serial_input, stb, oe_n, serial_output, cm, irq;
   logic [2:0] addr;
   logic [7:0] wdata, chan, sinks, rdata, shr, olat, cfg, ev, ien, d;
   logic [6:0] gain;
   logic [1:0] phase;
   lmd_phase_t ph;
   int err_count, checks, seed;

   lmd_mode_ctrl dut (.I_CLK_SYS(clk), .I_RSTN(rst_n), .I_CE(ce), .I_SCLK(sclk),
      .I_SERIAL_INPUT(serial_input), .I_STROBE_PIN_MULTI(stb), .I_OE_TRIG_N(oe_n),
      .I_CHAN_LOW_CUR(chan), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd_s),
      .O_SINK_CHANNELS(sinks), .O_SERIAL_OUTPUT(serial_output), .O_CURRENT_MULT(cm),
      .O_GAIN_CODE(gain), .O_PHASE(phase), .O_IRQ(irq), .O_RDATA(rdata));
   lmd_ctl_model ctl (.i_clk(clk), .o_sclk(sclk), .o_sdi(serial_input), .o_strobe(stb), .o_oe_n(oe_n));

   // 50 ns system clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic final_report;
      if (err_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask : rd_reg

   // Let the synchronisers settle, then compare every output but the read data with the model
   task automatic chk_pins;
      repeat (4) @(posedge clk);
      #1;
      `CHK(phase, ph)
      `CHK(serial_output, shr[7])
      `CHK({cm, gain}, cfg)
      `CHK(sinks, oe_n ? 8'h00 : olat)
      `CHK(irq, |(ev & ien))
   endtask : chk_pins

   task automatic mode(input logic sel);
      ctl.mode_sel(sel);
      shr = {shr[3:0], 4'h0};
      ev[`LMD_EV_SWITCH] = 1'b1;
      ev[sel ? `LMD_EV_SPECIAL : `LMD_EV_NORMAL] = 1'b1;
      ph = sel ? LMD_SPECIAL : LMD_NORMAL;
      chk_pins;
   endtask : mode

   task automatic load_byte(input logic [7:0] b);
      ctl.send_byte(b);
      shr = b;
      ctl.strobe_pulse();
   endtask : load_byte

   // Hang guard: the whole sequence needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      final_report;
   end

   initial begin
      seed = 82759;
      {rst_n, wr, rd_s, addr, wdata, chan, shr, olat, ev, ien} = '0;
      cfg = 8'hFF;
      ce = 1'b1;
      ph = LMD_NORMAL;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      chk_pins;
      rd_reg(`LMD_ADR_CFG, 8'hFF);
      rd_reg(`LMD_ADR_CLR, 8'h00);
      wr_reg(`LMD_ADR_IEN, 8'h3F);
      ien = 8'h3F;
      rd_reg(`LMD_ADR_IEN, 8'h3F);
      // Normal mode: shift, latch, light while enabled, blank after
      repeat (3) begin
         d = 8'($random(seed));
         load_byte(d);
         olat = shr;
         fork
            ctl.detect(10);
            begin
               repeat (5) @(posedge clk);
               #1;
               `CHK(sinks, olat)
            end
         join
         chk_pins;
      end
      // Long low enable in normal mode must not load error flags
      chan <= 8'($random(seed));
      ctl.detect(60);
      chk_pins;
      rd_reg(`LMD_ADR_SHR, shr);
      // Strobe high at selection picks special mode and latches nothing
      mode(1'b1);
      rd_reg(`LMD_ADR_OLAT, olat);
      rd_reg(`LMD_ADR_PHASE, 8'(ph));
      d = 8'($random(seed));
      load_byte(d);
      cfg = d;
      ev[`LMD_EV_CFG] = 1'b1;
      chk_pins;
      rd_reg(`LMD_ADR_OLAT, olat);
      // Detect: below-threshold channels store a low flag
      chan <= 8'($random(seed)) | 8'h10;
      ctl.detect(60);
      shr = ~chan;
      ev[`LMD_EV_DET] = 1'b1;
      ev[`LMD_EV_ERR] = 1'b1;
      chk_pins;
      rd_reg(`LMD_ADR_EVT, ev);
      // Flags leave on the serial output, top bit first
      for (int i = 0; i < 8; i++) begin
         #1;
         `CHK(serial_output, shr[7])
         ctl.bit_clk(1'b0, 1'b1);
         shr = {shr[6:0], 1'b0};
      end
      // Mask, unmask and clear the sticky events
      wr_reg(`LMD_ADR_IEN, 8'h00);
      ien = 8'h00;
      chk_pins;
      wr_reg(`LMD_ADR_IEN, 8'h3F);
      ien = 8'h3F;
      wr_reg(`LMD_ADR_CLR, 8'hFF);
      ev = 8'h00;
      chk_pins;
      rd_reg(`LMD_ADR_EVT, 8'h00);
      // Clock enable low freezes state, so a write in that cycle is lost
      ce <= 1'b0;
      wr_reg(`LMD_ADR_IEN, 8'h00);
      ce <= 1'b1;
      rd_reg(`LMD_ADR_IEN, ien);
      // Trigger seen in special mode and strobe low at selection return to normal; strobe then feeds the output latch
      mode(1'b0);
      d = 8'($random(seed));
      load_byte(d);
      olat = d;
      chk_pins;
      // Forced blanking keeps channels dark even with the enable low
      wr_reg(`LMD_ADR_CTRL, 8'h01);
      fork
         ctl.detect(10);
         begin
            repeat (5) @(posedge clk);
            #1;
            `CHK(sinks, 8'h00)
         end
      join
      wr_reg(`LMD_ADR_CTRL, 8'h00);
      rd_reg(`LMD_ADR_CTRL, 8'h00);
      rd_reg(`LMD_ADR_CFG, cfg);
      rd_reg(`LMD_ADR_OLAT, olat);
      final_report;
   end
endmodule : tb_top
